// ==== tslr_top.sv ====
// trigger sequencer broadcast enable and limit registers with step execution
`timescale 1ns/1ns
`include "tslr_defs.svh"
module tslr_top (
	input  wire logic        aclk,                   // system clock, 125 MHz
	input  wire logic        aresetn,                // synchronous reset, active low
	input  wire logic [7:0]  s_axi_awaddr,           // write address
	input  wire logic        s_axi_awvalid,          // write address valid
	output logic             s_axi_awready,          // write address ready
	input  wire logic [31:0] s_axi_wdata,            // write data
	input  wire logic [3:0]  s_axi_wstrb,            // write byte enables
	input  wire logic        s_axi_wvalid,           // write data valid
	output logic             s_axi_wready,           // write data ready
	output logic [1:0]       s_axi_bresp,            // write response
	output logic             s_axi_bvalid,           // write response valid
	input  wire logic        s_axi_bready,           // write response ready
	input  wire logic [7:0]  s_axi_araddr,           // read address
	input  wire logic        s_axi_arvalid,          // read address valid
	output logic             s_axi_arready,          // read address ready
	output logic [31:0]      s_axi_rdata,            // read data
	output logic [1:0]       s_axi_rresp,            // read response
	output logic             s_axi_rvalid,           // read response valid
	input  wire logic        s_axi_rready,           // read response ready
	input  wire logic        cmd_valid,              // step command offered
	input  wire logic [3:0]  cmd_opcode,             // step command code
	input  wire logic [3:0]  cmd_option,             // step command option
	output logic             cmd_ready,              // step command taken
	output logic             step_done,              // step completion pulse
	output logic             compare_one_clock_pulse, // clock pulse to compare unit one
	output logic [3:0]       compare_trigger_pulse,  // trigger pulses, units four..one
	output logic             converter_channel_select_wr,   // channel select write
	output logic [15:0]      converter_channel_select_data, // channel select value
	output logic             ext_adjust_valid,       // add to a limit held outside
	output logic [3:0]       ext_adjust_target,      // which outside limit
	output logic [15:0]      adjust_value,           // adjust register value
	output logic [15:0]      step_delay_limit,       // step delay limit value
	output logic [15:0]      counter0_limit,         // counter 0 limit value
	output logic [15:0]      literal_zero            // literal zero value
);
	tslr_pkg::tslr_top_state_type q, d;
	tslr_regbus_if bus ();

	logic t_busy;
	logic t_fin;
	logic t_done;
	logic running;
	logic accept;
	logic is_bcast;
	logic is_lit;
	logic is_add;

	// ============================================================
	// bus slave and step timer
	tslr_axi_slave u_axi (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.bus           (bus)
	);

	tslr_step_timer u_timer (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.start     (accept),
		.limit     (q.sdlim),
		.busy      (t_busy),
		.finishing (t_fin),
		.done      (t_done)
	);

	assign running  = q.en & q.start;
	assign accept   = cmd_valid & q.ready;
	assign is_bcast = (cmd_opcode == `TSLR_OP_CTRL) & (cmd_option == `TSLR_OPT_BCAST);
	assign is_lit   = (cmd_opcode == `TSLR_OP_CTRL) & (cmd_option == `TSLR_OPT_LITERAL);
	assign is_add   = (cmd_opcode == `TSLR_OP_ADD);

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = data[7:0];
		end
		if (strb[1]) begin
			r[15:8] = data[15:8];
		end
		return r;
	endfunction

	// ============================================================
	// address decode and read mux
	always_comb begin
		unique case (bus.wr_addr)
			`TSLR_OFF_BCAST, `TSLR_OFF_SDLIM, `TSLR_OFF_C0LIM, `TSLR_OFF_ADJ,
			`TSLR_OFF_L0, `TSLR_OFF_CTRL, `TSLR_OFF_STATUS: bus.wr_err = 1'b0;
			default: bus.wr_err = 1'b1;
		endcase
	end

	always_comb begin
		bus.rd_data = 32'h00000000;
		bus.rd_err  = 1'b0;
		unique case (bus.rd_addr)
			`TSLR_OFF_BCAST: bus.rd_data[15:0] = q.bcast;
			`TSLR_OFF_SDLIM: bus.rd_data[15:0] = q.sdlim;
			`TSLR_OFF_C0LIM: bus.rd_data[15:0] = q.c0lim;
			`TSLR_OFF_ADJ:   bus.rd_data[15:0] = q.adj;
			`TSLR_OFF_L0:    bus.rd_data[15:0] = q.l0;
			`TSLR_OFF_CTRL: begin
				bus.rd_data[`TSLR_CTRL_EN_BIT]    = q.en;
				bus.rd_data[`TSLR_CTRL_START_BIT] = q.start;
			end
			`TSLR_OFF_STATUS: begin
				bus.rd_data[`TSLR_STAT_BUSY_BIT] = t_busy;
				bus.rd_data[`TSLR_STAT_RUN_BIT]  = running;
			end
			default: bus.rd_err = 1'b1;
		endcase
	end

	// ============================================================
	// register writes and command execution
	always_comb begin
		d = q;
		d.clk_pulse = 1'b0;
		d.trig      = 4'h0;
		d.chsel_wr  = 1'b0;
		d.ext_add   = 1'b0;
		if (bus.wr_en) begin
			if (bus.wr_addr == `TSLR_OFF_CTRL) begin
				if (bus.wr_strb[0]) begin
					d.en    = bus.wr_data[`TSLR_CTRL_EN_BIT];
					d.start = bus.wr_data[`TSLR_CTRL_START_BIT];
				end
			end else if (!running) begin
				unique case (bus.wr_addr)
					`TSLR_OFF_BCAST: d.bcast = merge16(q.bcast, bus.wr_data, bus.wr_strb);
					`TSLR_OFF_SDLIM: d.sdlim = merge16(q.sdlim, bus.wr_data, bus.wr_strb);
					`TSLR_OFF_C0LIM: d.c0lim = merge16(q.c0lim, bus.wr_data, bus.wr_strb);
					`TSLR_OFF_ADJ:   d.adj   = merge16(q.adj, bus.wr_data, bus.wr_strb);
					`TSLR_OFF_L0:    d.l0    = merge16(q.l0, bus.wr_data, bus.wr_strb);
					default: ;
				endcase
			end
		end
		if (accept) begin
			if (is_bcast) begin
				d.clk_pulse = q.bcast[`TSLR_BCAST_CLK_BIT];
				d.trig      = q.bcast[`TSLR_BCAST_TRIG_HI:`TSLR_BCAST_TRIG_LO];
			end else if (is_lit) begin
				d.chsel_wr   = 1'b1;
				d.chsel_data = q.l0;
			end else if (is_add) begin
				unique case (cmd_option)
					`TSLR_ADD_SDLIM: d.sdlim = q.sdlim + q.adj;
					`TSLR_ADD_C0LIM: d.c0lim = q.c0lim + q.adj;
					`TSLR_ADD_L0:    d.l0    = q.l0 + q.adj;
					`TSLR_ADD_TIMER0, `TSLR_ADD_TIMER1, `TSLR_ADD_C1LIM: begin
						d.ext_add    = 1'b1;
						d.ext_target = cmd_option;
					end
					default: ;
				endcase
			end
		end
		// next command only after the current step delay has run out
		d.ready = d.en & d.start & ~accept & (~t_busy | t_fin);
		if (!aresetn) begin
			d = '0;
		end
	end

	always_ff @(posedge aclk) begin
		q <= d;
	end

	// ============================================================
	// outputs
	assign cmd_ready                     = q.ready;
	assign step_done                     = t_done;
	assign compare_one_clock_pulse       = q.clk_pulse;
	assign compare_trigger_pulse         = q.trig;
	assign converter_channel_select_wr   = q.chsel_wr;
	assign converter_channel_select_data = q.chsel_data;
	assign ext_adjust_valid              = q.ext_add;
	assign ext_adjust_target             = q.ext_target;
	assign adjust_value                  = q.adj;
	assign step_delay_limit              = q.sdlim;
	assign counter0_limit                = q.c0lim;
	assign literal_zero                  = q.l0;

	// ============================================================
	// checks
	a_clock_pulse_set: assert property (@(posedge aclk) disable iff (!aresetn)
		accept & is_bcast & q.bcast[`TSLR_BCAST_CLK_BIT] |=> q.clk_pulse)
		else $error("enabled broadcast gave no clock pulse");
	a_clock_pulse_cause: assert property (@(posedge aclk) disable iff (!aresetn)
		q.clk_pulse |-> $past(accept & is_bcast & q.bcast[`TSLR_BCAST_CLK_BIT]))
		else $error("clock pulse without enabled broadcast");
	a_trigger_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		accept & is_bcast |=> q.trig == $past(q.bcast[3:0]))
		else $error("trigger pulses differ from enable bits");
	a_trigger_only_bcast: assert property (@(posedge aclk) disable iff (!aresetn)
		!(accept & is_bcast) |=> q.trig == 4'h0 && !q.clk_pulse)
		else $error("pulse from a non-broadcast command");
	a_locked_write: assert property (@(posedge aclk) disable iff (!aresetn)
		bus.wr_en & running & !accept |=> $stable(q.bcast) && $stable(q.sdlim)
			&& $stable(q.c0lim) && $stable(q.adj) && $stable(q.l0))
		else $error("register changed by a write while running");
	a_counter0_write: assert property (@(posedge aclk) disable iff (!aresetn)
		bus.wr_en & !running & (bus.wr_addr == `TSLR_OFF_C0LIM) & (bus.wr_strb[1:0] == 2'h3)
			|=> q.c0lim == $past(bus.wr_data[15:0]))
		else $error("counter 0 limit write lost");
	a_add_sdlim: assert property (@(posedge aclk) disable iff (!aresetn)
		accept & is_add & (cmd_option == `TSLR_ADD_SDLIM)
			|=> q.sdlim == $past(q.sdlim) + $past(q.adj))
		else $error("add to step delay limit wrong");
	a_literal_chsel: assert property (@(posedge aclk) disable iff (!aresetn)
		accept & is_lit |=> q.chsel_wr && q.chsel_data == $past(q.l0))
		else $error("literal not sent to channel select");
	a_pulse_single: assert property (@(posedge aclk) disable iff (!aresetn)
		q.clk_pulse |=> !q.clk_pulse && q.trig == 4'h0)
		else $error("broadcast pulse longer than one clock");
	a_ready_wait: assert property (@(posedge aclk) disable iff (!aresetn)
		accept |=> !q.ready)
		else $error("command taken during step delay");

	c_broadcast: cover property (@(posedge aclk) disable iff (!aresetn)
		accept & is_bcast & (q.bcast[4:0] == 5'h1F));
	c_add_step: cover property (@(posedge aclk) disable iff (!aresetn)
		accept & is_add);
	c_locked_write: cover property (@(posedge aclk) disable iff (!aresetn)
		bus.wr_en & running);
	c_step_done: cover property (@(posedge aclk) disable iff (!aresetn)
		t_done & (q.sdlim != 16'h0000));
endmodule // tslr_top

// ==== tslr_defs.svh ====
// constants for the trigger sequencer limit register block
`ifndef TSLR_DEFS_SVH
`define TSLR_DEFS_SVH

// ============================================================
// register map
`define TSLR_ADDR_W          8
`define TSLR_OFF_BCAST       8'h00
`define TSLR_OFF_SDLIM       8'h04
`define TSLR_OFF_C0LIM       8'h08
`define TSLR_OFF_ADJ         8'h0C
`define TSLR_OFF_L0          8'h10
`define TSLR_OFF_CTRL        8'h14
`define TSLR_OFF_STATUS      8'h18

// ============================================================
// field positions
`define TSLR_BCAST_CLK_BIT   4
`define TSLR_BCAST_TRIG_HI   3
`define TSLR_BCAST_TRIG_LO   0
`define TSLR_CTRL_EN_BIT     0
`define TSLR_CTRL_START_BIT  1
`define TSLR_STAT_BUSY_BIT   0
`define TSLR_STAT_RUN_BIT    1

// ============================================================
// reset values
`define TSLR_RST_REG16       16'h0000

// ============================================================
// commands and options
`define TSLR_OP_CTRL         4'h0
`define TSLR_OP_ADD          4'h1
`define TSLR_OPT_BCAST       4'hF
`define TSLR_OPT_LITERAL     4'hE
`define TSLR_ADD_TIMER0      4'h0
`define TSLR_ADD_TIMER1      4'h1
`define TSLR_ADD_SDLIM       4'h2
`define TSLR_ADD_C0LIM       4'h3
`define TSLR_ADD_C1LIM       4'h4
`define TSLR_ADD_L0          4'h5

// ============================================================
// bus responses
`define TSLR_RESP_OKAY       2'h0
`define TSLR_RESP_SLVERR     2'h2

`endif

// ==== tslr_pkg.sv ====
// state types of the trigger sequencer limit register block
package tslr_pkg;

	typedef struct packed {
		logic        aw_held;
		logic [7:0]  awaddr;
		logic        w_held;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        awready;
		logic        wready;
		logic        arready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} tslr_axi_state_type;

	typedef struct packed {
		logic [15:0] cnt;
		logic        busy;
		logic        done;
		logic [16:0] elapsed;
		logic [15:0] lim;
	} tslr_timer_state_type;

	typedef struct packed {
		logic [15:0] bcast;
		logic [15:0] sdlim;
		logic [15:0] c0lim;
		logic [15:0] adj;
		logic [15:0] l0;
		logic        en;
		logic        start;
		logic        ready;
		logic        clk_pulse;
		logic [3:0]  trig;
		logic        chsel_wr;
		logic [15:0] chsel_data;
		logic        ext_add;
		logic [3:0]  ext_target;
	} tslr_top_state_type;

endpackage

// ==== tslr_regbus_if.sv ====
// register access carrier between bus slave and register file
`timescale 1ns/1ns
interface tslr_regbus_if;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_err;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_err;

	modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		input wr_err, rd_data, rd_err);
	modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		output wr_err, rd_data, rd_err);
endinterface

// ==== tslr_axi_slave.sv ====
// axi4-lite slave front end of the register file
`timescale 1ns/1ns
`include "tslr_defs.svh"
module tslr_axi_slave (
	input  wire logic        aclk,           // system clock
	input  wire logic        aresetn,        // synchronous reset, active low
	input  wire logic [7:0]  s_axi_awaddr,   // write address
	input  wire logic        s_axi_awvalid,  // write address valid
	output logic             s_axi_awready,  // write address ready
	input  wire logic [31:0] s_axi_wdata,    // write data
	input  wire logic [3:0]  s_axi_wstrb,    // write byte enables
	input  wire logic        s_axi_wvalid,   // write data valid
	output logic             s_axi_wready,   // write data ready
	output logic [1:0]       s_axi_bresp,    // write response
	output logic             s_axi_bvalid,   // write response valid
	input  wire logic        s_axi_bready,   // write response ready
	input  wire logic [7:0]  s_axi_araddr,   // read address
	input  wire logic        s_axi_arvalid,  // read address valid
	output logic             s_axi_arready,  // read address ready
	output logic [31:0]      s_axi_rdata,    // read data
	output logic [1:0]       s_axi_rresp,    // read response
	output logic             s_axi_rvalid,   // read response valid
	input  wire logic        s_axi_rready,   // read response ready
	tslr_regbus_if.slave     bus             // register access
);
	tslr_pkg::tslr_axi_state_type q, d;

	assign bus.wr_en   = q.aw_held & q.w_held & ~q.bvalid;
	assign bus.wr_addr = q.awaddr;
	assign bus.wr_data = q.wdata;
	assign bus.wr_strb = q.wstrb;
	assign bus.rd_addr = s_axi_araddr;

	// ============================================================
	// channel handling
	always_comb begin
		d = q;
		if (s_axi_awvalid & q.awready) begin
			d.aw_held = 1'b1;
			d.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid & q.wready) begin
			d.w_held = 1'b1;
			d.wdata  = s_axi_wdata;
			d.wstrb  = s_axi_wstrb;
		end
		// write is done once both halves are held
		if (bus.wr_en) begin
			d.aw_held = 1'b0;
			d.w_held  = 1'b0;
			d.bvalid  = 1'b1;
			d.bresp   = bus.wr_err ? `TSLR_RESP_SLVERR : `TSLR_RESP_OKAY;
		end else if (q.bvalid & s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (s_axi_arvalid & q.arready) begin
			d.rvalid = 1'b1;
			d.rdata  = bus.rd_data;
			d.rresp  = bus.rd_err ? `TSLR_RESP_SLVERR : `TSLR_RESP_OKAY;
		end else if (q.rvalid & s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		d.awready = ~d.aw_held & ~d.bvalid;
		d.wready  = ~d.w_held & ~d.bvalid;
		d.arready = ~d.rvalid;
		if (!aresetn) begin
			d = '0;
		end
	end

	always_ff @(posedge aclk) begin
		q <= d;
	end

	assign s_axi_awready = q.awready;
	assign s_axi_wready  = q.wready;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;
endmodule // tslr_axi_slave

// ==== tslr_step_timer.sv ====
// step delay timer: completes limit plus one clocks after start
`timescale 1ns/1ns
module tslr_step_timer (
	input  wire logic        aclk,       // system clock
	input  wire logic        aresetn,    // synchronous reset, active low
	input  wire logic        start,      // one-cycle start of a step
	input  wire logic [15:0] limit,      // extra clocks of delay
	output logic             busy,       // step in progress
	output logic             finishing,  // last cycle of the step
	output logic             done        // one-cycle completion pulse
);
	tslr_pkg::tslr_timer_state_type q, d;

	assign finishing = q.busy & (q.cnt == 16'h0000);

	// ============================================================
	// countdown
	always_comb begin
		d = q;
		d.done = 1'b0;
		if (q.busy) begin
			d.elapsed = q.elapsed + 17'h00001;
		end
		if (start) begin
			d.cnt     = limit;
			d.lim     = limit;
			d.busy    = 1'b1;
			d.elapsed = 17'h00000;
		end else if (finishing) begin
			d.busy = 1'b0;
			d.done = 1'b1;
		end else if (q.busy) begin
			d.cnt = q.cnt - 16'h0001;
		end
		if (!aresetn) begin
			d = '0;
		end
	end

	always_ff @(posedge aclk) begin
		q <= d;
	end

	assign busy = q.busy;
	assign done = q.done;

	// ============================================================
	// checks
	a_step_delay_len: assert property (@(posedge aclk) disable iff (!aresetn)
		q.done |-> q.elapsed == {1'b0, q.lim} + 17'h00001)
		else $error("step delay is not limit plus one");
	a_zero_delay: assert property (@(posedge aclk) disable iff (!aresetn)
		start & (limit == 16'h0000) |=> ##1 q.done)
		else $error("zero step delay did not finish after one clock");
endmodule // tslr_step_timer

// ==== tslr_pulse_sink.sv ====
// receiving side model: compare units and converter seeing trigger pulses
`timescale 1ns/1ns
module tslr_pulse_sink (
	input  wire logic        aclk,        // system clock
	input  wire logic        clr,         // forget the pulses seen so far; chsel_q keeps its value
	input  wire logic        clock_pulse, // clock pulse to compare unit one
	input  wire logic [3:0]  trig,        // trigger pulses, units four..one
	input  wire logic        chsel_wr,    // channel select write strobe
	input  wire logic [15:0] chsel_data,  // channel select value
	output logic      [4:0]  pattern_q,   // last pulse pattern seen
	output logic      [1:0]  hits_q,      // cycles with any pulse since clear
	output logic      [15:0] chsel_q      // last channel select written
);
	initial pattern_q = 5'h00;
	initial hits_q = 2'h0;
	initial chsel_q = 16'h0000;
	// ============================================================
	// capture
	always @(posedge aclk) begin
		if (clr) begin
			pattern_q <= 5'h00;
			hits_q <= 2'h0;
		end else if (clock_pulse || (|trig)) begin
			pattern_q <= {clock_pulse, trig};
			hits_q <= hits_q + 2'h1;
		end
		if (chsel_wr)
			chsel_q <= chsel_data;
	end
endmodule // tslr_pulse_sink

// ==== tslr_top_bench.sv ====
// self-checking bench of the trigger sequencer limit registers
`timescale 1ns/1ns
`include "tslr_defs.svh"
module tslr_top_bench;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF, cmd_opcode = 4'h0, cmd_option = 4'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cmd_valid = 1'b0, clr = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        cmd_ready, step_done, compare_one_clock_pulse;
	logic        converter_channel_select_wr, ext_adjust_valid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, seen_hits;
	logic [3:0]  compare_trigger_pulse, ext_adjust_target;
	logic [15:0] converter_channel_select_data, adjust_value, step_delay_limit;
	logic [15:0] counter0_limit, literal_zero, seen_chsel, lfsr = 16'h0016;
	logic [4:0]  seen_pat;
	logic [4:0]  ext_seen = 5'h00;
	logic [3:0]  ext_codes [3] = '{`TSLR_ADD_TIMER0, `TSLR_ADD_TIMER1, `TSLR_ADD_C1LIM};
	logic [15:0] rv [5];
	logic [4:0]  pats [7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1F};
	logic [33:0] exp_q [$];
	integer      errors = 0, check_count = 0;

	always #4 aclk = ~aclk;

	tslr_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_valid, .cmd_opcode,
		.cmd_option, .cmd_ready, .step_done, .compare_one_clock_pulse, .compare_trigger_pulse,
		.converter_channel_select_wr, .converter_channel_select_data, .ext_adjust_valid,
		.ext_adjust_target, .adjust_value, .step_delay_limit, .counter0_limit, .literal_zero);

	tslr_pulse_sink far_side (.aclk, .clr, .clock_pulse(compare_one_clock_pulse),
		.trig(compare_trigger_pulse), .chsel_wr(converter_channel_select_wr),
		.chsel_data(converter_channel_select_data), .pattern_q(seen_pat),
		.hits_q(seen_hits), .chsel_q(seen_chsel));

	// ============================================================
	// reporting
	task automatic check(input logic [33:0] seen, input logic [33:0] expv);
		check_count++;
		if (seen !== expv) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic give_up;
		errors++;
		summarize();
	endtask

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// response watcher: takes the oldest note whenever an answer is accepted
	always @(posedge aclk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
			check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		else if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			check({s_axi_bresp, 32'h0}, exp_q.pop_front());
	end

	// far-side note of adds aimed at limits held outside
	always @(posedge aclk) begin
		if (clr)
			ext_seen <= 5'h00;
		else if (ext_adjust_valid === 1'b1)
			ext_seen <= {1'b1, ext_adjust_target};
	end

	// ============================================================
	// bus and command drivers
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
		integer n;
		exp_q.push_back({resp, 32'h0});
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		s_axi_bready <= 1'b0;
		if (n >= 100) give_up();
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] expv);
		integer n;
		exp_q.push_back(expv);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		s_axi_rready <= 1'b0;
		if (n >= 100) give_up();
	endtask

	task automatic setreg(input int i, input logic [15:0] v);
		wr(8'(i * 4), {16'hA5A5, v}, `TSLR_RESP_OKAY);
		rv[i] = v;
	endtask

	task automatic cmd(input logic [3:0] op, input logic [3:0] opt, input logic [4:0] ep);
		integer n;
		integer k;
		@(posedge aclk);
		clr <= 1'b1;
		cmd_valid <= 1'b1;
		cmd_opcode <= op;
		cmd_option <= opt;
		n = 0;
		do begin
			@(posedge aclk);
			clr <= 1'b0;
			n++;
		end while (cmd_ready !== 1'b1 && n < 50);
		cmd_valid <= 1'b0;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
		end while (step_done !== 1'b1 && k < 300);
		if (n >= 50 || k >= 300) give_up();
		check(34'(k), 34'(rv[1]) + 34'h2);
		check(34'(seen_pat), 34'(ep));
		check(34'(seen_hits), (ep != 5'h00) ? 34'h1 : 34'h0);
	endtask

	// ============================================================
	// main sequence
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 5; i++) rd(8'(i * 4), 34'h0);
		rd(8'h1C, {`TSLR_RESP_SLVERR, 32'h0});
		wr(8'h1C, 32'h0000FFFF, `TSLR_RESP_SLVERR);
		$display("test reset_and_map done");
		for (int i = 0; i < 5; i++) begin
			lfsr = lfsr_next(lfsr);
			setreg(i, (i == 1 || i == 3) ? (lfsr & 16'h0007) : lfsr);
			rd(8'(i * 4), {18'h0, rv[i]});
		end
		check(34'(adjust_value), 34'(rv[3]));
		$display("test register_access done");
		foreach (pats[p]) begin
			wr(`TSLR_OFF_CTRL, 32'h0, `TSLR_RESP_OKAY);
			setreg(0, {11'h0, pats[p]});
			setreg(1, 16'(p % 3));
			wr(`TSLR_OFF_CTRL, 32'h3, `TSLR_RESP_OKAY);
			cmd(`TSLR_OP_CTRL, `TSLR_OPT_BCAST, pats[p]);
		end
		$display("test broadcast done");
		rd(`TSLR_OFF_CTRL, 34'h3);
		rd(`TSLR_OFF_STATUS, 34'h2);
		cmd(4'h2, `TSLR_OPT_BCAST, 5'h00);
		cmd(`TSLR_OP_CTRL, `TSLR_OPT_LITERAL, 5'h00);
		check(34'(seen_chsel), 34'(rv[4]));
		cmd(`TSLR_OP_ADD, 4'hF, 5'h00);
		$display("test other_commands done");
		for (int i = 0; i < 5; i++) begin
			wr(8'(i * 4), 32'h00005A5A, `TSLR_RESP_OKAY);
			rd(8'(i * 4), {18'h0, rv[i]});
		end
		cmd(`TSLR_OP_CTRL, `TSLR_OPT_BCAST, 5'h1F);
		$display("test locked_writes done");
		cmd(`TSLR_OP_ADD, `TSLR_ADD_SDLIM, 5'h00);
		rv[1] = rv[1] + rv[3];
		check(34'(step_delay_limit), 34'(rv[1]));
		check(34'(ext_seen), 34'h0);
		cmd(`TSLR_OP_ADD, `TSLR_ADD_C0LIM, 5'h00);
		rv[2] = rv[2] + rv[3];
		check(34'(counter0_limit), 34'(rv[2]));
		cmd(`TSLR_OP_ADD, `TSLR_ADD_L0, 5'h00);
		rv[4] = rv[4] + rv[3];
		rd(`TSLR_OFF_L0, {18'h0, rv[4]});
		check(34'(literal_zero), 34'(rv[4]));
		foreach (ext_codes[e]) begin
			cmd(`TSLR_OP_ADD, ext_codes[e], 5'h00);
			check(34'(ext_seen), {30'h1, ext_codes[e]});
		end
		cmd(`TSLR_OP_CTRL, `TSLR_OPT_BCAST, 5'h1F);
		$display("test adjust done");
		repeat (4) @(posedge aclk);
		summarize();
	end
endmodule // tslr_top_bench
